// *** src/spmsp_port.sv ***
// Serial peripheral port core: master clocking, slave tracking, shifter, flags and pin drive.
`timescale 1ns/1ns
module spmsp_port
  import spmsp_pkg::*;
(
  input  wire logic                clk_i,                  // System clock, 50 MHz.
  input  wire logic                rst_n_i,                // Asynchronous reset, active low.
  input  wire logic                ctrl_wr_i,              // Control register write strobe.
  input  wire logic                ctrl_port_enable_i,     // Written port enable.
  input  wire logic                ctrl_master_select_i,   // Written master select.
  input  wire logic                ctrl_polarity_i,        // Written clock polarity.
  input  wire logic                ctrl_phase_i,           // Written clock phase.
  input  wire logic                ctrl_size16_i,          // Written transfer length.
  input  wire logic                ctrl_lsb_first_i,       // Written bit order.
  input  wire logic                ctrl_open_drain_i,      // Written open drain select.
  input  wire logic                ctrl_irq_enable_i,      // Written interrupt enable.
  input  wire logic [7:0]          ctrl_divider_i,         // Written clock divider field.
  input  wire logic                dir_wr_i,               // Pin direction write strobe.
  input  wire logic [NUM_PINS-1:0] dir_data_i,             // Written pin directions, 1 is output.
  input  wire logic                status_rd_i,            // Status register read strobe.
  input  wire logic                data_rd_i,              // Data register read strobe.
  input  wire logic                data_wr_i,              // Data register write strobe.
  input  wire logic [15:0]         data_wr_val_i,          // Data register write value.
  input  wire logic [NUM_PINS-1:0] pin_in_i,               // Pin levels from the pads.
  output logic                     port_enable_o,          // Port enable bit.
  output logic                     master_select_o,        // Master select bit.
  output logic                     transfer_done_flag_o,   // Transfer complete flag.
  output logic                     write_collision_flag_o, // Write collision flag.
  output logic                     mode_fault_flag_o,      // Mode fault flag.
  output logic [15:0]              serial_data_o,          // Received data buffer.
  output logic [NUM_PINS-1:0]      pin_direction_o,        // Pin direction register.
  output logic                     irq_o,                  // Interrupt request, active high.
  output logic [NUM_PINS-1:0]      pin_out_o,              // Pin output levels.
  output logic [NUM_PINS-1:0]      pin_oe_n_o              // Pin output enables, low drives.
);

  // Control register fields.
  logic         clock_polarity_select_reg; // Serial clock idle level.
  logic         clock_phase_select_reg;    // Transfer format.
  logic         size16_select_reg;         // Word transfers when set.
  logic         lsb_first_select_reg;      // LSB first when set.
  logic         open_drain_select_reg;     // Outputs only pull low.
  logic         transfer_irq_enable_reg;   // Interrupt enable.
  logic [7:0]   clock_divider_field_reg;   // Half period in system clocks.
  // Status arming captured by a status read.
  logic         done_armed_reg;            // Status read saw done set.
  logic         col_armed_reg;             // Status read saw collision set.
  logic         fault_armed_reg;           // Status read saw fault set.
  // Transfer state.
  spmsp_state_t state_reg;                 // Idle or running.
  logic [7:0]   div_cnt_reg;               // Modulus counter.
  logic [5:0]   tick_cnt_reg;              // Master half periods elapsed.
  logic [5:0]   edge_cnt_reg;              // Serial clock edges seen.
  logic [15:0]  shift_reg;                 // Shifter.
  logic         latch_reg;                 // Last sampled bit.
  logic         out_bit_reg;               // Bit presented on the data output.
  logic         sck_reg;                   // Generated serial clock.
  logic         sck_prev_reg;              // Previous filtered serial clock.
  logic         sel_prev_reg;              // Previous slave selection.
  logic [NUM_PINS-1:0] pin_lvl;            // Filtered pin levels.

  // Filter the pins into the system clock domain.
  spmsp_sync u_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .async_i (pin_in_i),
    .level_o (pin_lvl)
  );

  // Head bit of the shifter for the chosen length and order.
  function automatic logic head_bit(input logic [15:0] v, input logic w16, input logic lsb);
    head_bit = lsb ? v[0] : (w16 ? v[15] : v[7]);
  endfunction : head_bit

  // Shift one bit out of the head and insert a received bit at the tail.
  function automatic logic [15:0] shift_in(input logic [15:0] v, input logic b, input logic w16,
                                           input logic lsb);
    if (lsb) begin
      shift_in = w16 ? {b, v[15:1]} : {8'h00, b, v[7:1]};
    end else begin
      shift_in = w16 ? {v[14:0], b} : {8'h00, v[6:0], b};
    end
  endfunction : shift_in

  // Combinational timing terms.
  logic       master_run;   // Master transfer running.
  logic       div_ok;       // Divider in its active range.
  logic       tick_p;       // Half period boundary.
  logic [5:0] total_edges;  // Edges in one transfer.
  logic [5:0] tick_num;     // Half period number being reached.
  logic       m_edge_p;     // Master clock edge.
  logic       m_done_p;     // Master transfer complete.
  logic       s_sel;        // Slave selected.
  logic       s_edge_p;     // Slave clock edge.
  logic       s_done_p;     // Slave transfer complete.
  logic       edge_p;       // Any clock edge.
  logic       done_p;       // Any completion.
  logic       sample_p;     // Sampling edge.
  logic       shift_p;      // Shifting edge.
  logic       in_bit;       // Incoming data pin.
  logic       busy;         // Transfer in progress.
  logic       load_p;       // Accepted data write.
  logic       start_p;      // Master start.
  logic       collision_p;  // Refused data write.
  logic       fault_det;    // Mode fault detected.
  logic       flag_clear;   // Data access that may clear flags.

  assign total_edges = size16_select_reg ? EDGES_WORD : EDGES_BYTE;
  assign master_run  = (state_reg == ST_RUN) && master_select_o && port_enable_o;
  assign div_ok      = clock_divider_field_reg >= DIV_MIN;
  assign tick_p      = master_run && div_ok && (div_cnt_reg == clock_divider_field_reg - STEP8);
  assign tick_num    = tick_cnt_reg + STEP6;
  assign m_edge_p    = tick_p && (tick_num <= total_edges);
  // In phase one the master completes one half period late.
  assign m_done_p    = tick_p && (tick_num == (clock_phase_select_reg ? total_edges + STEP6 : total_edges));
  assign s_sel       = port_enable_o && !master_select_o && !pin_lvl[PIN_SS];
  assign s_edge_p    = s_sel && (pin_lvl[PIN_SCK] != sck_prev_reg) && (edge_cnt_reg < total_edges);
  assign s_done_p    = s_edge_p && (edge_cnt_reg + STEP6 == total_edges);
  assign edge_p      = m_edge_p || s_edge_p;
  assign done_p      = m_done_p || s_done_p;
  // The edge being taken is odd while the count so far is even.
  // Odd and even edge roles.
  assign sample_p    = edge_p && (!edge_cnt_reg[0] != clock_phase_select_reg);
  assign shift_p     = edge_p && !sample_p;
  assign in_bit      = master_select_o ? pin_lvl[PIN_MISO] : pin_lvl[PIN_MOSI];
  // Busy window per role and phase.
  assign busy        = (state_reg == ST_RUN) || (s_sel && !clock_phase_select_reg);
  assign load_p      = data_wr_i && !busy;
  assign start_p     = load_p && port_enable_o && master_select_o;
  assign collision_p = data_wr_i && busy;
  assign fault_det   = port_enable_o && master_select_o && !pin_lvl[PIN_SS] && !pin_direction_o[PIN_SS];
  assign flag_clear  = data_rd_i || load_p;

  // Control register: written fields, with fault forcing role and enable off.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      port_enable_o             <= 1'b0;
      master_select_o           <= 1'b0;
      clock_polarity_select_reg <= 1'b0;
      clock_phase_select_reg    <= 1'b0;
      size16_select_reg         <= 1'b0;
      lsb_first_select_reg      <= 1'b0;
      open_drain_select_reg     <= 1'b0;
      transfer_irq_enable_reg   <= 1'b0;
      clock_divider_field_reg   <= DIV_RESET;
    end else begin
      if (ctrl_wr_i) begin
        clock_polarity_select_reg <= ctrl_polarity_i;
        clock_phase_select_reg    <= ctrl_phase_i;
        size16_select_reg         <= ctrl_size16_i;
        lsb_first_select_reg      <= ctrl_lsb_first_i;
        open_drain_select_reg     <= ctrl_open_drain_i;
        transfer_irq_enable_reg   <= ctrl_irq_enable_i;
        clock_divider_field_reg   <= ctrl_divider_i;
      end
      if (fault_det) begin
        port_enable_o   <= 1'b0;
        master_select_o <= 1'b0;
      end else if (ctrl_wr_i && (!mode_fault_flag_o || fault_armed_reg)) begin
        port_enable_o   <= ctrl_port_enable_i;
        master_select_o <= ctrl_master_select_i;
      end
    end
  end

  // Pin direction register; a fault turns all but slave select to inputs.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_direction_o <= DIR_RESET;
    end else if (fault_det) begin
      pin_direction_o <= pin_direction_o & FAULT_DIR_MASK;
    end else if (dir_wr_i) begin
      pin_direction_o <= dir_data_i;
    end
  end

  // Status flags and their read-then-access clearing; a set wins over a clear.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      transfer_done_flag_o   <= 1'b0;
      write_collision_flag_o <= 1'b0;
      mode_fault_flag_o      <= 1'b0;
      done_armed_reg         <= 1'b0;
      col_armed_reg          <= 1'b0;
      fault_armed_reg        <= 1'b0;
    end else begin
      if (status_rd_i) begin
        done_armed_reg  <= transfer_done_flag_o;
        col_armed_reg   <= write_collision_flag_o;
        fault_armed_reg <= mode_fault_flag_o;
      end else begin
        if (flag_clear) begin
          done_armed_reg <= 1'b0;
          col_armed_reg  <= 1'b0;
        end
        if (ctrl_wr_i) begin
          fault_armed_reg <= 1'b0;
        end
      end
      if (done_p) begin
        transfer_done_flag_o <= 1'b1;
      end else if (flag_clear && (done_armed_reg || col_armed_reg)) begin
        transfer_done_flag_o <= 1'b0;
      end
      if (collision_p) begin
        write_collision_flag_o <= 1'b1;
      end else if (flag_clear && col_armed_reg) begin
        write_collision_flag_o <= 1'b0;
      end
      if (fault_det) begin
        mode_fault_flag_o <= 1'b1;
      end else if (ctrl_wr_i && fault_armed_reg) begin
        mode_fault_flag_o <= 1'b0;
      end
    end
  end

  // Interrupt request from done or fault, never from a collision.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= transfer_irq_enable_reg && (transfer_done_flag_o || mode_fault_flag_o);
    end
  end

  // Transfer state, modulus counter and edge counters.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg    <= ST_IDLE;
      div_cnt_reg  <= 8'h00;
      tick_cnt_reg <= 6'h00;
      edge_cnt_reg <= 6'h00;
      sck_prev_reg <= 1'b0;
      sel_prev_reg <= 1'b0;
    end else begin
      sck_prev_reg <= pin_lvl[PIN_SCK];
      sel_prev_reg <= s_sel;
      if (!master_run || !div_ok || tick_p) begin
        div_cnt_reg <= 8'h00;
      end else begin
        div_cnt_reg <= div_cnt_reg + STEP8;
      end
      if (start_p) begin
        state_reg    <= ST_RUN;
        tick_cnt_reg <= 6'h00;
        edge_cnt_reg <= 6'h00;
      end else if (done_p || !port_enable_o || (!master_select_o && !s_sel)) begin
        state_reg    <= ST_IDLE;
        tick_cnt_reg <= 6'h00;
        edge_cnt_reg <= 6'h00;
      end else begin
        // Slave phase one starts at first edge.
        if (s_edge_p && clock_phase_select_reg) begin
          state_reg <= ST_RUN;
        end
        if (tick_p) begin
          tick_cnt_reg <= tick_num;
        end
        if (edge_p) begin
          edge_cnt_reg <= edge_cnt_reg + STEP6;
        end
      end
    end
  end

  // Generated serial clock; rests at the polarity level outside transfers.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sck_reg <= 1'b0;
    end else if (!master_run) begin
      sck_reg <= clock_polarity_select_reg;
    end else if (m_edge_p) begin
      sck_reg <= !sck_reg;
    end
  end

  // Shifter, sample latch, output bit and receive buffer.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shift_reg     <= DATA_RESET;
      latch_reg     <= 1'b0;
      out_bit_reg   <= 1'b0;
      serial_data_o <= DATA_RESET;
    end else begin
      if (sample_p) begin
        latch_reg <= in_bit;
      end
      if (load_p) begin
        shift_reg   <= data_wr_val_i;
        out_bit_reg <= head_bit(data_wr_val_i, size16_select_reg, lsb_first_select_reg);
      end else if (done_p) begin
        shift_reg     <= shift_in(shift_reg, (clock_phase_select_reg && s_done_p) ? in_bit : latch_reg,
                                  size16_select_reg, lsb_first_select_reg);
        serial_data_o <= shift_in(shift_reg, (clock_phase_select_reg && s_done_p) ? in_bit : latch_reg,
                                  size16_select_reg, lsb_first_select_reg);
      end else if (shift_p) begin
        shift_reg <= shift_in(shift_reg, latch_reg, size16_select_reg, lsb_first_select_reg);
        out_bit_reg <= clock_phase_select_reg
                       ? head_bit(shift_reg, size16_select_reg, lsb_first_select_reg)
                       : head_bit(shift_in(shift_reg, latch_reg, size16_select_reg, lsb_first_select_reg),
                                  size16_select_reg, lsb_first_select_reg);
      end else if (s_sel && !sel_prev_reg) begin
        // Each select presents the first bit.
        out_bit_reg <= head_bit(shift_reg, size16_select_reg, lsb_first_select_reg);
      end
    end
  end

  // Pin drive, one flop pair per pin; open drain only pulls low.
  logic [NUM_PINS-1:0] pin_val; // Level each pin would carry.
  assign pin_val = {1'b1, out_bit_reg, out_bit_reg, sck_reg};
  genvar gp;
  generate
    for (gp = 0; gp < NUM_PINS; gp++) begin : g_drive
      always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          pin_out_o[gp]  <= 1'b0;
          pin_oe_n_o[gp] <= 1'b1;
        end else begin
          pin_out_o[gp]  <= open_drain_select_reg ? 1'b0 : pin_val[gp];
          pin_oe_n_o[gp] <= !(pin_direction_o[gp] && (!open_drain_select_reg || !pin_val[gp]));
        end
      end
    end
  endgenerate

  // Checks on the block's own behaviour.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  collision_flag_a: assert property (collision_p |=> write_collision_flag_o &&
                                     ($stable(shift_reg) || $past(edge_p || done_p)))
    else $error("refused write did not raise collision");
  mode_fault_a: assert property (fault_det |=> mode_fault_flag_o && !port_enable_o && !master_select_o)
    else $error("mode fault not handled");
  fault_dir_a: assert property (fault_det |=> pin_direction_o[PIN_MISO:PIN_SCK] == 3'h0)
    else $error("fault left outputs enabled");
  fault_lock_a: assert property (mode_fault_flag_o && !(ctrl_wr_i && fault_armed_reg) |=> !port_enable_o)
    else $error("enable set while fault stands");
  done_irq_a: assert property (transfer_done_flag_o && transfer_irq_enable_reg |=> irq_o)
    else $error("done did not request interrupt");
  done_clear_a: assert property (data_rd_i && done_armed_reg && !status_rd_i && !done_p |=> !transfer_done_flag_o)
    else $error("done flag not cleared");
  div_stop_a: assert property ((master_run && !div_ok) [*2] |-> $stable(sck_reg))
    else $error("clock moved with divider off");
  half_period_a: assert property (m_edge_p |=> !m_edge_p)
    else $error("edges closer than two clocks");
  last_half_a: assert property (m_done_p && clock_phase_select_reg |-> sck_reg == clock_polarity_select_reg)
    else $error("clock not idle at end");
  master_edges_a: assert property (m_done_p |-> edge_cnt_reg + {5'h00, m_edge_p} == total_edges)
    else $error("master done at wrong edge");
  open_drain_a: assert property (open_drain_select_reg |=> pin_out_o == 4'h0)
    else $error("open drain pin driven high");
  first_bit_a: assert property (load_p && !lsb_first_select_reg && !size16_select_reg |=> out_bit_reg == $past(data_wr_val_i[7]))
    else $error("wrong first bit");

  master_done_c: cover property (m_done_p);
  slave_done_c: cover property (s_done_p);
  collision_c: cover property (collision_p);
  fault_c: cover property (fault_det);

endmodule : spmsp_port

// *** src/spmsp_pkg.sv ***
// Shared constants and types for the serial peripheral master/slave port.
package spmsp_pkg;

  // Pin count and pin positions inside every pin vector.
  localparam int          NUM_PINS       = 4;
  localparam int          PIN_SCK        = 0;
  localparam int          PIN_MOSI       = 1;
  localparam int          PIN_MISO       = 2;
  localparam int          PIN_SS         = 3;

  // Smallest divider value that runs the clock generator.
  localparam logic [7:0]  DIV_MIN        = 8'h02;
  // Reset values of the control and data state.
  localparam logic [7:0]  DIV_RESET      = 8'h00;
  localparam logic [15:0] DATA_RESET     = 16'h0000;
  localparam logic [3:0]  DIR_RESET      = 4'h0;
  // Only the slave select direction survives a mode fault.
  localparam logic [3:0]  FAULT_DIR_MASK = 4'h8;
  // Synchroniser reset level: slave select idles high, the rest low.
  localparam logic [3:0]  SYNC_RESET     = 4'h8;

  // Serial clock edges in a byte and in a word transfer.
  localparam logic [5:0]  EDGES_BYTE     = 6'h10;
  localparam logic [5:0]  EDGES_WORD     = 6'h20;
  // Counter steps used in arithmetic.
  localparam logic [5:0]  STEP6          = 6'h01;
  localparam logic [7:0]  STEP8          = 8'h01;

  // Transfer state of the shifter.
  typedef enum logic {ST_IDLE, ST_RUN} spmsp_state_t;

endpackage : spmsp_pkg

// *** src/spmsp_sync.sv ***
// Three-stage pin synchroniser with agreement filter for the serial port pins.
`timescale 1ns/1ns
module spmsp_sync
  import spmsp_pkg::*;
(
  input  wire logic                clk_i,   // System clock.
  input  wire logic                rst_n_i, // Asynchronous reset, active low.
  input  wire logic [NUM_PINS-1:0] async_i, // Raw pin levels.
  output logic      [NUM_PINS-1:0] level_o  // Filtered pin levels.
);

  // One synchroniser per pin.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
      logic s1_reg; // First stage, read only by the second.
      logic s2_reg; // Second stage.
      logic s3_reg; // Third stage.
      // Shift the raw level through three flops; accept it once stages two and three agree.
      always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          s1_reg        <= SYNC_RESET[gi];
          s2_reg        <= SYNC_RESET[gi];
          s3_reg        <= SYNC_RESET[gi];
          level_o[gi]   <= SYNC_RESET[gi];
        end else begin
          s1_reg <= async_i[gi];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          if (s2_reg == s3_reg) begin
            level_o[gi] <= s3_reg;
          end
        end
      end
    end
  endgenerate

endmodule : spmsp_sync

// *** verif/spmsp_slave_model.sv ***
// External slave for the serial port bench, clock phase zero, polarity zero.
`timescale 1ns/1ns
module spmsp_slave_model (
  input  wire logic       sck_i,   // Serial clock from the pad.
  input  wire logic       mosi_i,  // Data from the master.
  input  wire logic       sel_n_i, // Select of this slave, active low.
  input  wire logic [7:0] tx_i,    // Byte this slave sends.
  output logic            miso_o,  // Data to the master.
  output logic [7:0]      rx_o     // Byte this slave received.
);
  logic [2:0] cnt_reg = 3'h0; // Bits already shifted out in this selection.
  always @(posedge sck_i) rx_o <= {rx_o[6:0], mosi_i};
  // shift even edges; a deselect rewinds to the first bit.
  always @(posedge sel_n_i or negedge sck_i) begin
    if (sel_n_i) cnt_reg <= 3'h0;
    else cnt_reg <= cnt_reg + 3'h1;
  end
  // A released line shows the inverse of the current bit, so stale data never passes.
  assign miso_o = sel_n_i ? ~tx_i[3'h7 - cnt_reg] : tx_i[3'h7 - cnt_reg];
endmodule : spmsp_slave_model

// *** verif/serial_peripheral_master_slave_port_bench.sv ***
// Self-checking bench driving the serial port core against a slave model.
`timescale 1ns/1ns
module serial_peripheral_master_slave_port_bench
  import spmsp_pkg::*;
;
  logic clk = 0, rst_n = 0, cw = 0, dw = 0, sr = 0, drd = 0, dirw = 0, ss_n = 1, sel_n = 1;
  logic [7:0]  cb = 8'h00, dv = 8'h00, rx;
  logic [15:0] wv = 16'h0000, sd;
  logic [3:0]  dd = 4'h0, dir, po, oen;
  logic        pe, ms, done, write_collision_flag, mode_fault_flag, irq, miso;
  int          n_mismatch = 0, tests_run = 0, ncyc = 0, n;
  logic [1:0]  ext = 2'b11; // Bench pulls on sck and mosi when it plays the external master.
  // Released sck and mosi pads are pulled up; the bench can pull them low.
  wire [3:0] pin = {ss_n, oen[2] ? miso : po[2], (oen[1:0] | po[1:0]) & ext};
  always #10 clk = ~clk;
  spmsp_port i_dut (.clk_i(clk), .rst_n_i(rst_n), .ctrl_wr_i(cw), .ctrl_port_enable_i(cb[7]),
    .ctrl_master_select_i(cb[6]), .ctrl_polarity_i(cb[5]), .ctrl_phase_i(cb[4]), .ctrl_size16_i(cb[3]),
    .ctrl_lsb_first_i(cb[2]), .ctrl_open_drain_i(cb[1]), .ctrl_irq_enable_i(cb[0]), .ctrl_divider_i(dv),
    .dir_wr_i(dirw), .dir_data_i(dd), .status_rd_i(sr), .data_rd_i(drd), .data_wr_i(dw), .data_wr_val_i(wv),
    .pin_in_i(pin), .port_enable_o(pe), .master_select_o(ms), .transfer_done_flag_o(done),
    .write_collision_flag_o(write_collision_flag), .mode_fault_flag_o(mode_fault_flag), .serial_data_o(sd), .pin_direction_o(dir),
    .irq_o(irq), .pin_out_o(po), .pin_oe_n_o(oen));
  spmsp_slave_model i_slave (.sck_i(pin[0]), .mosi_i(pin[1]), .sel_n_i(sel_n), .tx_i(8'h3C), .miso_o(miso),
    .rx_o(rx));
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask : chk
  // One-cycle strobe between falling edges.
  task automatic pulse(ref logic s);
    @(negedge clk) s = 1;
    @(negedge clk) s = 0;
  endtask : pulse
  task automatic ctl(logic [7:0] b, logic [7:0] d);
    cb = b;
    dv = d;
    pulse(cw);
  endtask : ctl
  task automatic wr(logic [15:0] v);
    wv = v;
    pulse(dw);
  endtask : wr
  // Bounded wait for completion, then status read and data read.
  task automatic fin;
    n = 0;
    while (done !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    chk("irq", irq, 1);
    chk("rx data", sd, 16'h003C);
    pulse(sr);
    pulse(drd);
    @(negedge clk);
    chk("done clear", done, 0);
    chk("collision clear", write_collision_flag, 0);
    sel_n = 1;
  endtask : fin
  task automatic t_master;
    dd = 4'h3;
    pulse(dirw);
    // Divider 8 leaves room for the three-flop pin filter on the returning data.
    ctl(8'hC1, 8'h08);
    sel_n = 0;
    wr(16'h00A5);
    @(posedge po[0]);
    n = 0;
    @(negedge clk);
    while (po[0] === 1'b1) begin
      n++;
      @(negedge clk);
    end
    chk("half period", n, 8);
    wr(16'h00FF);
    @(negedge clk);
    chk("collision", write_collision_flag, 1);
    chk("no irq", irq, 0);
    fin;
    chk("slave rx", rx, 8'hA5);
  endtask : t_master
  task automatic t_lsb;
    ctl(8'hC7, 8'h08);
    sel_n = 0;
    wr(16'h0001);
    chk("open drain", po, 4'h0);
    fin;
    chk("lsb rx", rx, 8'h80);
  endtask : t_lsb
  task automatic t_div0;
    ctl(8'hC0, 8'h00);
    wr(16'h00A5);
    n = 0;
    repeat (40) begin
      @(negedge clk);
      if (po[0] !== 1'b0) n++;
    end
    chk("idle sck", n, 0);
  endtask : t_div0
  task automatic t_fault;
    ss_n = 0;
    repeat (6) @(negedge clk);
    chk("fault", mode_fault_flag, 1);
    chk("enable", {pe, ms, dir}, 6'h00);
    ctl(8'hC0, 8'h02);
    @(negedge clk);
    chk("locked", pe, 0);
    ss_n = 1;
    repeat (4) @(negedge clk);
    pulse(sr);
    ctl(8'hC0, 8'h02);
    @(negedge clk);
    chk("fault clear", {mode_fault_flag, pe}, 2'b01);
  endtask : t_fault
  // External master in phase one; select stays low across two transfers.
  task automatic t_slave;
    logic [7:0] got;
    logic [7:0] s;
    s = 8'h3C;
    ext = 2'b00;
    dd = 4'h4;
    pulse(dirw);
    ctl(8'h91, 8'h00);
    ss_n = 0;
    for (int k = 0; k < 2; k++) begin
      wr(k ? 16'h00C3 : 16'h005A);
      repeat (6) @(negedge clk);
      // Odd edges carry new data out, even edges take data in.
      for (int i = 7; i >= 0; i--) begin
        ext = {s[i], 1'b1};
        repeat (8) @(negedge clk);
        got = {got[6:0], pin[2]};
        ext[0] = 1'b0;
        repeat (8) @(negedge clk);
      end
      fin;
      chk("slave tx", got, k ? 8'hC3 : 8'h5A);
    end
  endtask : t_slave
  task automatic end_of_test;
    $display("comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_of_test
  // Cuts a hang short well past the expected few hundred cycles.
  always @(posedge clk) begin
    ncyc++;
    if (ncyc == 3000) begin
      n_mismatch++;
      end_of_test;
    end
  end
  initial begin
    repeat (6) @(negedge clk);
    rst_n = 1;
    t_master;
    t_lsb;
    t_div0;
    t_fault;
    t_slave;
    end_of_test;
  end
endmodule : serial_peripheral_master_slave_port_bench
